// ### hdl/uart_bus_if.sv
// Pin-level carrier between the UART device end and its host
`timescale 1ns/1ps
interface uart_bus_if;
   logic bus_style;
   logic reset_pin;
   logic cs_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic [2:0] addr;
   logic [7:0] host_d_o;
   logic host_d_oe_n;
   logic [7:0] dev_d_o;
   logic dev_d_oe_n;
   logic int_o;
   logic int_oe_n;
   logic txd;
   logic rxd;
   logic pump_autosleep;
   logic [7:0] data;
   logic int_line;
   // Undriven data bus floats high through the pull-ups
   assign data = !dev_d_oe_n ? dev_d_o : (!host_d_oe_n ? host_d_o : 8'hFF);
   // Open-drain style needs the pull-up; strobe style rests low when off
   assign int_line = !int_oe_n ? int_o : !bus_style;
   modport dev (
      input bus_style, reset_pin, cs_n, read_strobe_n, write_strobe_n,
      input addr, data, rxd, pump_autosleep,
      output dev_d_o, dev_d_oe_n, int_o, int_oe_n, txd
   );
   modport host (
      input data, int_line, txd,
      output bus_style, reset_pin, cs_n, read_strobe_n, write_strobe_n,
      output addr, host_d_o, host_d_oe_n, rxd, pump_autosleep
   );
endinterface

// ### hdl/uart_bus_pkg.sv
// Shared constants for the UART host bus port ends
package uart_bus_pkg;
   // ----------------------------------------
   // Bus styles and line levels
   // ----------------------------------------
   localparam logic STYLE_STROBE = 1'b1;
   localparam logic STYLE_DIR = 1'b0;
   localparam logic LINE_MARK = 1'b1;
   localparam logic DIR_READ = 1'b1;
   localparam logic DIR_WRITE = 1'b0;
   // ----------------------------------------
   // Device register file
   // ----------------------------------------
   localparam int NUM_REGS = 8;
   localparam logic [2:0] MODEM_CTRL_IDX = 3'h4;
   localparam int INT_EN_BIT = 3;
   localparam logic [7:0] REG_RST = 8'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 8;
   localparam int RST_MIN_NS = 40;
   localparam int RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int PHASE_CYC = 4;
   localparam int STROBE_CYC = 2 * PHASE_CYC;
   // ----------------------------------------
   // Host controller APB map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WDATA_OFS = 8'h04;
   localparam logic [7:0] RDATA_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;
   localparam logic [7:0] ISR_OFS = 8'h10;
   localparam logic [7:0] IMR_OFS = 8'h14;
   localparam logic [7:0] LINE_OFS = 8'h18;
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_ADDR_LSB = 4;
   localparam int CTRL_STYLE = 8;
   localparam int CTRL_RESET = 9;
   localparam int CTRL_PUMP = 10;
   localparam int EV_DONE = 0;
   localparam int EV_DEVINT = 1;
endpackage

// ### hdl/uart_port_dev.sv
// Device end of the UART parallel host port
`timescale 1ns/1ps
// Function
// - Style pin high selects strobes, low direction
// - Read strobe fall drives addressed register byte
// - Host captures read byte at strobe rise
// - Write strobe rise stores data byte
// - Direction style ignores the read strobe
// - Direction style: write pin high reads, low writes
// - Accesses only while chip select low
// - Strobe style: interrupt high, enabled by control bit
// - Direction style: interrupt open-drain, low pending
// - Direction style software keeps enable bit zero
// - Transmit line marks in reset and idle
// - Remote keeps receive line marking when idle
// - Autosleep pin stops pump in partial sleep
// - Reset polarity follows style, clears registers
module uart_port_dev
   import uart_bus_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins
   uart_bus_if.dev bus,
   // UART core side
   input wire logic irq_pending,
   input wire logic tx_active,
   input wire logic tx_bit,
   input wire logic partial_sleep,
   output logic rx_bit,
   output logic pump_off,
   output logic wr_valid,
   output logic [2:0] wr_index,
   output logic [7:0] wr_data,
   output logic int_enable
);
   import uart_bus_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int SW = 18;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] s1_r;
   logic [SW-1:0] s2_r;
   logic [SW-1:0] prev_r;
   // Resets to idle pin levels so no false edge follows reset
   localparam logic [SW-1:0] PIN_IDLE = {STYLE_STROBE, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 8'hFF, LINE_MARK, 1'b0};
   assign pin_raw = {bus.bus_style, bus.reset_pin, bus.cs_n,
                     bus.read_strobe_n, bus.write_strobe_n, bus.addr,
                     bus.data, bus.rxd, bus.pump_autosleep};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         prev_r <= PIN_IDLE;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         prev_r <= s2_r;
      end
   end

   logic style;
   logic rst_pin;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [2:0] addr;
   logic [7:0] din;
   logic rxd_s;
   logic pump_s;
   assign {style, rst_pin, cs_n, rd_n, wr_n, addr, din, rxd_s, pump_s} = s2_r;

   // ----------------------------------------
   // Reset pin and bus decode
   // ----------------------------------------
   logic pin_rst;
   logic strobe_mode;
   assign strobe_mode = (style == STYLE_STROBE);
   // Polarity flips with the style strap
   assign pin_rst = strobe_mode ? rst_pin : !rst_pin;

   logic cs_fall;
   logic cs_rise;
   logic rd_fall;
   logic wr_fall;
   logic wr_rise;
   logic p_cs_n;
   logic p_rd_n;
   logic p_wr_n;
   assign p_cs_n = prev_r[15];
   assign p_rd_n = prev_r[14];
   assign p_wr_n = prev_r[13];
   assign cs_fall = p_cs_n && !cs_n;
   assign cs_rise = !p_cs_n && cs_n;
   // Strobe edges count only while selected
   assign rd_fall = strobe_mode && !cs_n && p_rd_n && !rd_n;
   assign wr_fall = strobe_mode && !cs_n && p_wr_n && !wr_n;
   assign wr_rise = strobe_mode && !cs_n && !p_wr_n && wr_n;

   // ----------------------------------------
   // Access tracking
   // ----------------------------------------
   logic rd_act_r;
   logic wr_arm_r;
   logic rd_start;
   logic rd_end;
   logic wr_commit;
   // Direction style never looks at the read strobe
   assign rd_start = strobe_mode ? rd_fall : (cs_fall && wr_n == DIR_READ);
   assign rd_end = cs_n || (strobe_mode && rd_n);
   // Data must be stable at the strobe rise; it is sampled there
   assign wr_commit = wr_arm_r && (strobe_mode ? wr_rise : cs_rise);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_act_r <= 1'b0;
      else if (pin_rst)
         rd_act_r <= 1'b0;
      else if (rd_start)
         rd_act_r <= 1'b1;
      else if (rd_end)
         rd_act_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wr_arm_r <= 1'b0;
      else if (pin_rst)
         wr_arm_r <= 1'b0;
      else if (strobe_mode && wr_fall)
         wr_arm_r <= 1'b1;
      else if (!strobe_mode && cs_fall && wr_n == DIR_WRITE)
         wr_arm_r <= 1'b1;
      else if (wr_commit || (strobe_mode && cs_n))
         wr_arm_r <= 1'b0;
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [7:0] reg_r [NUM_REGS];
   logic [2:0] wr_idx_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wr_idx_r <= '0;
      else if (rd_start || wr_fall || cs_fall)
         wr_idx_r <= addr;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               reg_r[gi] <= REG_RST;
            else if (pin_rst)
               reg_r[gi] <= REG_RST;
            else if (wr_commit && wr_idx_r == 3'(gi))
               reg_r[gi] <= din;
         end
      end
   endgenerate

   logic int_en;
   assign int_en = reg_r[MODEM_CTRL_IDX][INT_EN_BIT];

   // ----------------------------------------
   // Data bus driver
   // ----------------------------------------
   logic [7:0] d_o_r;
   logic d_oe_n_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         d_o_r <= '0;
         d_oe_n_r <= 1'b1;
      end
      else
      begin
         if (rd_start)
            d_o_r <= reg_r[addr];
         d_oe_n_r <= pin_rst || !((rd_act_r && !rd_end) || rd_start);
      end
   end

   // ----------------------------------------
   // Interrupt pin
   // ----------------------------------------
   logic int_o_r;
   logic int_oe_n_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_o_r <= 1'b0;
         int_oe_n_r <= 1'b1;
      end
      else if (pin_rst)
      begin
         int_o_r <= 1'b0;
         int_oe_n_r <= 1'b1;
      end
      else if (strobe_mode)
      begin
         int_o_r <= irq_pending;
         int_oe_n_r <= !int_en;
      end
      else
      begin
         // Only ever pulls low; the pull-up gives the idle level
         int_o_r <= 1'b0;
         int_oe_n_r <= !irq_pending;
      end
   end

   // ----------------------------------------
   // Serial lines and charge pump
   // ----------------------------------------
   logic txd_r;
   logic rx_bit_r;
   logic pump_off_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txd_r <= LINE_MARK;
         rx_bit_r <= LINE_MARK;
         pump_off_r <= 1'b0;
      end
      else
      begin
         txd_r <= (pin_rst || !tx_active) ? LINE_MARK : tx_bit;
         // Receiver sees marking while held in reset
         rx_bit_r <= pin_rst ? LINE_MARK : rxd_s;
         pump_off_r <= pump_s && partial_sleep && !pin_rst;
      end
   end

   // ----------------------------------------
   // Core-side write report
   // ----------------------------------------
   logic wr_valid_r;
   logic [2:0] wr_index_r;
   logic [7:0] wr_data_r;
   logic int_enable_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_valid_r <= 1'b0;
         wr_index_r <= '0;
         wr_data_r <= '0;
         int_enable_r <= 1'b0;
      end
      else
      begin
         wr_valid_r <= wr_commit;
         if (wr_commit)
         begin
            wr_index_r <= wr_idx_r;
            wr_data_r <= din;
         end
         int_enable_r <= int_en;
      end
   end

   assign bus.dev_d_o = d_o_r;
   assign bus.dev_d_oe_n = d_oe_n_r;
   assign bus.int_o = int_o_r;
   assign bus.int_oe_n = int_oe_n_r;
   assign bus.txd = txd_r;
   assign rx_bit = rx_bit_r;
   assign pump_off = pump_off_r;
   assign wr_valid = wr_valid_r;
   assign wr_index = wr_index_r;
   assign wr_data = wr_data_r;
   assign int_enable = int_enable_r;
endmodule // uart_port_dev

// ### hdl/uart_port_host.sv
// Host end: APB-controlled master of the UART parallel port
`timescale 1ns/1ps
module uart_port_host
   import uart_bus_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Pins
   uart_bus_if.host bus
);
   import uart_bus_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} hstate_t;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [8:0] s1_r;
   logic [8:0] s2_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= {bus.int_line, bus.data};
         s2_r <= s1_r;
      end
   end

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   logic access;
   logic wr_en;
   logic style_r;
   logic pump_r;
   logic is_wr_r;
   logic [2:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] rdata_r;
   logic [1:0] isr_r;
   logic [1:0] imr_r;
   logic [1:0] line_r;
   logic [1:0] ev;
   logic go;
   logic rst_go;
   logic busy;
   logic [3:0] rst_cnt_r;
   hstate_t st_r;
   assign access = psel && penable && !pready;
   // Writes land at the edge where the master sees pready
   assign wr_en = psel && penable && pready && pwrite;
   assign go = wr_en && paddr == CTRL_OFS && pwdata[CTRL_GO] && !busy;
   assign rst_go = wr_en && paddr == CTRL_OFS && pwdata[CTRL_RESET];
   assign busy = st_r != H_IDLE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         style_r <= STYLE_STROBE;
         pump_r <= 1'b0;
         is_wr_r <= 1'b0;
         addr_r <= '0;
         wdata_r <= '0;
         imr_r <= '0;
         line_r <= '0;
      end
      else if (wr_en && !busy)
      begin
         if (paddr == CTRL_OFS)
         begin
            style_r <= pwdata[CTRL_STYLE];
            pump_r <= pwdata[CTRL_PUMP];
            is_wr_r <= pwdata[CTRL_WRITE];
            addr_r <= pwdata[CTRL_ADDR_LSB +: 3];
         end
         if (paddr == WDATA_OFS)
            wdata_r <= pwdata[7:0];
         if (paddr == IMR_OFS)
            imr_r <= pwdata[1:0];
         if (paddr == LINE_OFS)
            line_r <= pwdata[1:0];
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         isr_r <= '0;
      else if (wr_en && paddr == ISR_OFS)
         isr_r <= (isr_r & ~pwdata[1:0]) | ev;
      else
         isr_r <= isr_r | ev;
   end

   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      unique case (paddr)
         CTRL_OFS: rd_mux = {21'h0, pump_r, 1'b0, style_r, 1'b0, addr_r, 2'h0, is_wr_r, 1'b0};
         WDATA_OFS: rd_mux = {24'h0, wdata_r};
         RDATA_OFS: rd_mux = {24'h0, rdata_r};
         STAT_OFS: rd_mux = {30'h0, rst_cnt_r != 4'h0, busy};
         ISR_OFS: rd_mux = {30'h0, isr_r};
         IMR_OFS: rd_mux = {30'h0, imr_r};
         LINE_OFS: rd_mux = {30'h0, line_r};
         default: rd_mux = '0;
      endcase
   end

   logic mapped;
   assign mapped = paddr inside {CTRL_OFS, WDATA_OFS, RDATA_OFS, STAT_OFS, ISR_OFS, IMR_OFS, LINE_OFS};

   // One wait state keeps every APB output on a flip-flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
         irq <= 1'b0;
      end
      else
      begin
         pready <= access;
         pslverr <= access && !mapped;
         prdata <= (access && !pwrite) ? rd_mux : '0;
         irq <= |(isr_r & imr_r);
      end
   end

   // ----------------------------------------
   // Reset pulse, at least the minimum width
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rst_cnt_r <= '0;
      else if (rst_go)
         rst_cnt_r <= 4'(RST_CYC + 2);
      else if (rst_cnt_r != 4'h0)
         rst_cnt_r <= rst_cnt_r - 4'h1;
   end

   // ----------------------------------------
   // Port access sequencer
   // ----------------------------------------
   logic [3:0] cnt_r;
   logic cs_n_r;
   logic rd_n_r;
   logic wr_n_r;
   logic d_oe_n_r;
   logic [7:0] d_o_r;
   logic modem_ctl_wr;
   // Open-drain interrupt only works with the enable bit clear
   assign modem_ctl_wr = !style_r && addr_r == MODEM_CTRL_IDX;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= H_IDLE;
         cnt_r <= '0;
         cs_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         d_oe_n_r <= 1'b1;
         d_o_r <= '0;
         rdata_r <= '0;
      end
      else
      begin
         cnt_r <= (cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1;
         unique case (st_r)
            H_IDLE:
               if (go)
               begin
                  st_r <= H_SETUP;
                  cnt_r <= 4'(PHASE_CYC);
               end
            H_SETUP:
            begin
               d_oe_n_r <= !is_wr_r;
               d_o_r <= modem_ctl_wr ? (wdata_r & ~(8'h01 << INT_EN_BIT)) : wdata_r;
               if (!style_r)
                  wr_n_r <= is_wr_r ? DIR_WRITE : DIR_READ;
               if (cnt_r == 4'h0)
               begin
                  st_r <= H_STROBE;
                  cnt_r <= 4'(STROBE_CYC);
                  cs_n_r <= 1'b0;
                  if (style_r)
                  begin
                     rd_n_r <= is_wr_r;
                     wr_n_r <= !is_wr_r;
                  end
               end
            end
            H_STROBE:
               if (cnt_r == 4'h0)
               begin
                  st_r <= H_HOLD;
                  cnt_r <= 4'(PHASE_CYC);
                  if (!is_wr_r)
                     rdata_r <= s2_r[7:0];
                  rd_n_r <= 1'b1;
                  if (style_r)
                     wr_n_r <= 1'b1;
                  else
                     cs_n_r <= 1'b1;
               end
            H_HOLD:
               if (cnt_r == 4'h0)
               begin
                  st_r <= H_IDLE;
                  cs_n_r <= 1'b1;
                  wr_n_r <= 1'b1;
                  d_oe_n_r <= 1'b1;
               end
         endcase
      end
   end

   logic devint;
   assign devint = style_r ? s2_r[8] : !s2_r[8];
   assign ev[EV_DONE] = st_r == H_HOLD && cnt_r == 4'h0;
   assign ev[EV_DEVINT] = devint;

   assign bus.bus_style = style_r;
   assign bus.reset_pin = (rst_cnt_r != 4'h0) ? style_r : !style_r;
   assign bus.cs_n = cs_n_r;
   assign bus.read_strobe_n = rd_n_r;
   assign bus.write_strobe_n = wr_n_r;
   assign bus.addr = addr_r;
   assign bus.host_d_o = d_o_r;
   assign bus.host_d_oe_n = d_oe_n_r;
   // Receive line marks unless software sends a level
   assign bus.rxd = line_r[0] ? line_r[1] : LINE_MARK;
   assign bus.pump_autosleep = pump_r;
endmodule // uart_port_host

// ### tb/uart_host_bus_port_test.sv
// Self-checking bench joining both port ends
`timescale 1ns/1ps
module uart_host_bus_port_test;
   import uart_bus_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, chk_r, pmp;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, irq, irq_pending, tx_active, tx_bit, partial_sleep;
   logic rx_bit, pump_off, wr_valid, int_enable;
   logic [2:0] wr_index;
   logic [7:0] wr_data;
   logic [7:0] mdl [8];
   logic [32:0] apq [$];
   logic [10:0] wrq [$];
   int err_total, comparisons, seed;
   uart_bus_if bus_if();
   uart_port_dev uart_port_dev_inst(.pclk(pclk), .presetn(presetn), .bus(bus_if),
      .irq_pending(irq_pending), .tx_active(tx_active), .tx_bit(tx_bit), .partial_sleep(partial_sleep),
      .rx_bit(rx_bit), .pump_off(pump_off), .wr_valid(wr_valid), .wr_index(wr_index),
      .wr_data(wr_data), .int_enable(int_enable));
   uart_port_host uart_port_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .bus(bus_if));
   uart_port_properties uart_port_properties_inst(.pclk(pclk), .presetn(presetn),
      .bus_style(bus_if.bus_style), .reset_pin(bus_if.reset_pin), .cs_n(bus_if.cs_n),
      .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
      .addr(bus_if.addr), .host_d_o(bus_if.host_d_o), .host_d_oe_n(bus_if.host_d_oe_n),
      .dev_d_oe_n(bus_if.dev_d_oe_n), .int_o(bus_if.int_o), .int_oe_n(bus_if.int_oe_n),
      .txd(bus_if.txd));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      chk_r <= c;
      if (c) apq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk_r <= 1'b0;
   endtask
   // Polls busy; the watchdog covers a port that never finishes
   task automatic acc(input logic st, input logic w, input logic [2:0] a, input logic [7:0] d);
      logic [31:0] c;
      c = 32'h0000_0000;
      c[CTRL_GO] = 1'b1;
      c[CTRL_WRITE] = w;
      c[CTRL_ADDR_LSB+:3] = a;
      c[CTRL_STYLE] = st;
      c[CTRL_PUMP] = pmp;
      if (w)
      begin
         if (!st && a == MODEM_CTRL_IDX) d[INT_EN_BIT] = 1'b0;
         mdl[a] = d;
         wrq.push_back({a, d});
         apb(1'b1, WDATA_OFS, {24'h00_0000, d}, 1'b0, 33'h0);
      end
      apb(1'b1, CTRL_OFS, c, 1'b0, 33'h0);
      cyc(2);
      do apb(1'b0, STAT_OFS, 32'h0, 1'b0, 33'h0); while (r[0] !== 1'b0);
      if (!w) apb(1'b0, RDATA_OFS, 32'h0, 1'b1, {9'h000, 16'h0000, mdl[a]});
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, monitors, watchdog
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (pready === 1'b1 && chk_r) chk({pslverr, prdata}, apq.pop_front());
      if (wr_valid === 1'b1) chk({wr_index, wr_data}, wrq.pop_front());
   end
   initial
   begin
      // Roughly twenty times the expected run length
      #200_000;
      err_total++;
      end_of_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, chk_r, pmp, irq_pending, tx_active, tx_bit, partial_sleep} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      seed = 55;
      foreach (mdl[i]) mdl[i] = REG_RST;
      cyc(12);
      presetn <= 1'b1;
      apb(1'b0, 8'h40, 32'h0, 1'b1, {1'b1, 32'h0000_0000});
      // Strobe style first, then direction style with bit masking
      for (int s = 1; s >= 0; s--)
      begin
         for (int i = 0; i < 8; i++) acc(s[0], 1'b1, i[2:0], 8'($random(seed)));
         for (int i = 0; i < 8; i++) acc(s[0], 1'b0, i[2:0], 8'h00);
      end
      acc(1'b1, 1'b1, MODEM_CTRL_IDX, 8'h08);
      chk(int_enable, 1'b1);
      apb(1'b1, ISR_OFS, 32'h0000_0003, 1'b0, 33'h0);
      apb(1'b1, IMR_OFS, 32'h0000_0002, 1'b0, 33'h0);
      irq_pending <= 1'b1;
      cyc(10);
      chk({bus_if.int_line, irq}, 2'b11);
      apb(1'b0, ISR_OFS, 32'h0, 1'b1, 33'h2);
      acc(1'b1, 1'b1, MODEM_CTRL_IDX, 8'h00);
      cyc(6);
      chk(bus_if.int_line, 1'b0);
      acc(1'b0, 1'b1, MODEM_CTRL_IDX, 8'h00);
      cyc(6);
      chk(bus_if.int_line, 1'b0);
      irq_pending <= 1'b0;
      cyc(6);
      chk(bus_if.int_line, 1'b1);
      apb(1'b1, ISR_OFS, 32'h0000_0003, 1'b0, 33'h0);
      cyc(2);
      chk(irq, 1'b0);
      // Pin reset pulse must clear the register file
      acc(1'b1, 1'b1, 3'h2, 8'hA5);
      apb(1'b1, CTRL_OFS, 32'h0000_0300, 1'b0, 33'h0);
      cyc(20);
      foreach (mdl[i]) mdl[i] = REG_RST;
      acc(1'b1, 1'b0, 3'h2, 8'h00);
      partial_sleep <= 1'b1;
      apb(1'b1, CTRL_OFS, 32'h0000_0500, 1'b0, 33'h0);
      cyc(8);
      chk(pump_off, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h0000_0100, 1'b0, 33'h0);
      cyc(8);
      chk(pump_off, 1'b0);
      tx_active <= 1'b1;
      cyc(6);
      chk(bus_if.txd, 1'b0);
      tx_active <= 1'b0;
      cyc(6);
      chk(bus_if.txd, 1'b1);
      apb(1'b1, LINE_OFS, 32'h0000_0001, 1'b0, 33'h0);
      cyc(6);
      chk(rx_bit, 1'b0);
      apb(1'b1, LINE_OFS, 32'h0000_0000, 1'b0, 33'h0);
      cyc(6);
      chk(rx_bit, 1'b1);
      chk(wrq.size() + apq.size(), 33'h0);
      end_of_test();
   end
endmodule // uart_host_bus_port_test

// ### tb/uart_port_properties.sv
// Pin-level checker for the UART host port carrier
`timescale 1ns/1ps
module uart_port_properties
   import uart_bus_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins
   input wire logic bus_style,
   input wire logic reset_pin,
   input wire logic cs_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] host_d_o,
   input wire logic host_d_oe_n,
   input wire logic dev_d_oe_n,
   input wire logic int_o,
   input wire logic int_oe_n,
   input wire logic txd
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Data bus ownership
   // ----------------------------------------
   // Release allows three cycles for the pin synchronisers
   cs_release_a: assert property (cs_n [*4] |-> dev_d_oe_n)
      else $error("device drives data without chip select");
   no_contention_a: assert property (!(!dev_d_oe_n && !host_d_oe_n))
      else $error("both ends drive data");
   read_drive_a: assert property ((bus_style && !cs_n && !read_strobe_n) [*7] |-> !dev_d_oe_n)
      else $error("read byte not driven");
   dir_write_a: assert property ((!bus_style && !write_strobe_n) [*4] |-> dev_d_oe_n)
      else $error("device drives during direction write");
   write_data_a: assert property (bus_style && !write_strobe_n |-> !host_d_oe_n && $stable(host_d_o))
      else $error("write byte not held during strobe");
   strobe_cs_a: assert property (!read_strobe_n || (bus_style && !write_strobe_n) |-> !cs_n)
      else $error("strobe outside chip select");
   // ----------------------------------------
   // Interrupt, line and reset
   // ----------------------------------------
   open_drain_a: assert property (!bus_style && !int_oe_n |-> !int_o)
      else $error("open-drain interrupt driven high");
   int_en_bit_a: assert property (!bus_style && !cs_n && !write_strobe_n && addr == MODEM_CTRL_IDX
      && !host_d_oe_n |-> !host_d_o[INT_EN_BIT])
      else $error("enable bit set in direction style");
   tx_mark_a: assert property ((bus_style ? reset_pin : !reset_pin) [*4] |-> txd)
      else $error("transmit line not marking in reset");
endmodule // uart_port_properties
